// ===== acs_pkg.sv
// Purpose: Shared constants for the converter sequencer
// Assumes: 20 MHz system clock, 32-bit register port
// Notes: Offsets are byte addresses within the block
package acs_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_CONTROL = 8'h00; // Control and done flags
	localparam logic [7:0] OFS_DELAY = 8'h04; // Start and repeat delays
	localparam logic [7:0] OFS_STATUS = 8'h08; // Busy status
	localparam logic [7:0] OFS_ONESHOT_EN = 8'h0c; // One-shot channel enables
	localparam logic [7:0] OFS_PERIODIC_EN = 8'h10; // Repeat channel enables
	localparam logic [7:0] OFS_RESULT0 = 8'h14; // First result register
	localparam logic [7:0] OFS_RESULT1 = 8'h18; // Channel 1 result
	localparam logic [7:0] OFS_RESULT2 = 8'h1c; // Channel 2 result
	localparam logic [7:0] OFS_RESULT3 = 8'h20; // Channel 3 result
	localparam logic [7:0] OFS_RESULT4 = 8'h24; // Channel 4 result
	// ----------------------------------------
	// Control field positions, channel count and result width
	// ----------------------------------------
	localparam int BIT_ACTIVATE = 0; // Block enable
	localparam int BIT_START_ONESHOT = 1; // Self-clearing start
	localparam int BIT_START_REPEAT = 2; // Repeat mode
	localparam int BIT_POWER_SAVER_DIS = 3; // Keep analog powered
	localparam int BIT_SOFT_RESET = 4; // Sequencer reset
	localparam int BIT_REPEAT_DONE = 6; // Repeat done flag
	localparam int BIT_ONESHOT_DONE = 7; // One-shot done flag
	localparam int NUM_CHANNELS = 5; // Input channels
	localparam int RESULT_WIDTH = 10; // Result word width
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [31:0] RST_CONTROL = 32'h0000_0000; // All off
	localparam logic [31:0] RST_DELAY = 32'h0000_0000; // Zero delays
	localparam logic [4:0] RST_CHAN_EN = 5'h00; // No channels
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int SYS_CLOCK_KHZ = 20000; // System clock rate
	localparam int SEQ_CLOCK_KHZ = 1200; // Sequencing clock rate
	localparam int SEQ_DIV = SYS_CLOCK_KHZ / SEQ_CLOCK_KHZ; // Cycles per tick, rounded down
	localparam int CONV_TIME_NS = 12000; // Longest conversion time
	localparam int SEQ_TICK_NS = 1000000 / SEQ_CLOCK_KHZ; // Sequencing tick period
	localparam int CONV_TICKS = CONV_TIME_NS / SEQ_TICK_NS; // Ticks, rounded down
	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001, // Waiting for a request
		ST_PICK = 3'b010, // Choosing next channel
		ST_CONV = 3'b100 // Converting one channel
	} acs_state_type;
endpackage : acs_pkg

// ===== acs_sequencer.sv
// Purpose: Conversion sequencer and register bank for a five-channel converter
// Assumes: Register port is synchronous, single-cycle read data
// Notes: Analog result arrives on sample_data when the conversion ends
//
// Operation
// - Sequencing runs on derived 1.25 MHz tick
// - Reset clears all registers but the start-delay status flag, and sequencing
// - One-shot completion interrupt output
// - Repeat completion interrupt output
// - Sleep gates clocking only
// - Activate low disables converter
// - Channels converted lowest to highest, skipping disabled
// - Ten-bit result, under 12 us
// - Start on one-shot bit or timer zero
// - One-shot cycle uses one-shot enables
// - Repeat cycle uses repeat enables
// - One-shot wins when both pending
// - Start delay precedes first repeat cycle
// - Repeat cycles follow at repeat interval
// - Repeat done set at end, cleared at start
// - Timer expiry during one-shot runs afterward
// - One-shot begins without delay
// - One-shot done set at end, cleared at start
// - One-shot during repeat runs afterward
// - Frequent one-shots starve repeat cycles
// - One-shot start bit self-clears
// - Done flags clear on written one
// - Deactivate finishes current cycle first
// - Clearing repeat keeps current cycle
module acs_sequencer
	import acs_pkg::*;
(
	input wire logic clock, // System clock
	input wire logic rst_n, // Main-well reset, active low
	input wire logic sleep_req, // Sleep request from power control
	input wire logic [7:0] reg_addr, // Register byte offset
	input wire logic reg_wr, // Write strobe
	input wire logic [31:0] reg_wdata, // Write data
	input wire logic reg_rd, // Read strobe
	input wire logic [9:0] sample_data, // Converter core result
	output logic [31:0] reg_rdata, // Registered read data
	output logic [2:0] mux_sel, // Analog channel select
	output logic conv_start, // Converter sampling pulse
	output logic analog_on, // Analog power enable
	output logic core_reset, // Converter core reset
	output logic oneshot_irq, // One-shot completion interrupt
	output logic repeat_irq // Repeat completion interrupt
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [31:0] control_reg; // Control register
	logic [31:0] delay_reg; // Start delay low, repeat delay high
	logic [4:0] oneshot_en_reg; // One-shot enables
	logic [4:0] periodic_en_reg; // Repeat enables
	logic [9:0] result_reg [NUM_CHANNELS]; // Per-channel readings
	logic [4:0] div_reg; // Tick divider
	logic tick; // 1.25 MHz enable pulse
	logic [15:0] timer_reg; // Repeat countdown
	logic timer_first_reg; // Counting the start delay
	logic repeat_pend_reg; // Repeat cycle pending
	logic oneshot_pend_reg; // One-shot cycle pending
	logic active_is_oneshot_reg; // Cycle kind in progress
	logic [4:0] remain_reg; // Channels left in this cycle
	logic [4:0] conv_cnt_reg; // Conversion tick count
	logic activate_prev_reg; // For rising-edge core reset
	acs_state_type state_reg; // Sequencer state
	logic wr_ctl; // Control write
	logic seq_run; // Sequencer may advance
	logic seq_hold; // Soft reset holds sequencer
	logic cycle_end; // Last channel finished
	logic repeat_expire; // Timer reaches zero this tick

	// Lowest set bit index of an enable mask
	function automatic logic [2:0] lowest_chan(input logic [4:0] mask);
		lowest_chan = 3'h0;
		for (int i = NUM_CHANNELS - 1; i >= 0; i--) begin
			if (mask[i]) begin
				lowest_chan = 3'(i);
			end
		end
	endfunction : lowest_chan

	assign wr_ctl = reg_wr && (reg_addr == OFS_CONTROL);
	assign seq_hold = control_reg[BIT_SOFT_RESET];
	// Sleep freezes the divider only; analog power is untouched
	assign seq_run = tick && !seq_hold;
	assign cycle_end = seq_run && (state_reg == ST_CONV) && (conv_cnt_reg == 5'(CONV_TICKS - 1))
		&& ((remain_reg & ~(5'h01 << mux_sel)) == 5'h00);
	assign repeat_expire = seq_run && control_reg[BIT_START_REPEAT] && control_reg[BIT_ACTIVATE]
		&& (timer_reg == 16'h0000);

	// ----------------------------------------
	// Tick divider
	// ----------------------------------------
	// Sequencer steps on an enable pulse rather than a second clock
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= 5'h00;
			tick <= 1'b0;
		end else if (sleep_req) begin
			tick <= 1'b0; // Clocking gated while asleep
		end else if (div_reg == 5'(SEQ_DIV - 1)) begin
			div_reg <= 5'h00;
			tick <= 1'b1;
		end else begin
			div_reg <= div_reg + 5'h01;
			tick <= 1'b0;
		end
	end

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			control_reg <= RST_CONTROL;
		end else begin
			if (wr_ctl) begin
				control_reg[BIT_ACTIVATE] <= reg_wdata[BIT_ACTIVATE];
				control_reg[BIT_START_REPEAT] <= reg_wdata[BIT_START_REPEAT];
				control_reg[BIT_POWER_SAVER_DIS] <= reg_wdata[BIT_POWER_SAVER_DIS];
				control_reg[BIT_SOFT_RESET] <= reg_wdata[BIT_SOFT_RESET];
			end
			// Start bit lives one cycle, so a late tick cannot re-arm the request
			if (wr_ctl && reg_wdata[BIT_START_ONESHOT]) begin
				control_reg[BIT_START_ONESHOT] <= 1'b1;
			end else if (control_reg[BIT_START_ONESHOT]) begin
				control_reg[BIT_START_ONESHOT] <= 1'b0;
			end
			// Done flags: hardware set wins over a write-one clear
			if (cycle_end && active_is_oneshot_reg) begin
				control_reg[BIT_ONESHOT_DONE] <= 1'b1;
			end else if (seq_run && state_reg == ST_IDLE && oneshot_pend_reg
					&& control_reg[BIT_ACTIVATE]) begin
				control_reg[BIT_ONESHOT_DONE] <= 1'b0;
			end else if (wr_ctl && reg_wdata[BIT_ONESHOT_DONE]) begin
				control_reg[BIT_ONESHOT_DONE] <= 1'b0;
			end
			if (cycle_end && !active_is_oneshot_reg) begin
				control_reg[BIT_REPEAT_DONE] <= 1'b1;
			end else if (seq_run && state_reg == ST_IDLE && !oneshot_pend_reg
					&& repeat_pend_reg && control_reg[BIT_ACTIVATE]) begin
				control_reg[BIT_REPEAT_DONE] <= 1'b0;
			end else if (wr_ctl && reg_wdata[BIT_REPEAT_DONE]) begin
				control_reg[BIT_REPEAT_DONE] <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Other writable registers
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			delay_reg <= RST_DELAY;
			oneshot_en_reg <= RST_CHAN_EN;
			periodic_en_reg <= RST_CHAN_EN;
		end else if (reg_wr) begin
			if (reg_addr == OFS_DELAY) begin
				delay_reg <= reg_wdata;
			end
			if (reg_addr == OFS_ONESHOT_EN) begin
				oneshot_en_reg <= reg_wdata[4:0];
			end
			if (reg_addr == OFS_PERIODIC_EN) begin
				periodic_en_reg <= reg_wdata[4:0];
			end
		end
	end

	// ----------------------------------------
	// Request capture
	// ----------------------------------------
	// Pending requests survive a running cycle so it is never aborted
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			oneshot_pend_reg <= 1'b0;
			repeat_pend_reg <= 1'b0;
		end else if (seq_hold) begin
			oneshot_pend_reg <= 1'b0;
			repeat_pend_reg <= 1'b0;
		end else begin
			if (control_reg[BIT_START_ONESHOT]) begin
				oneshot_pend_reg <= 1'b1;
			end else if (seq_run && state_reg == ST_IDLE && control_reg[BIT_ACTIVATE]) begin
				oneshot_pend_reg <= 1'b0;
			end
			if (repeat_expire) begin
				repeat_pend_reg <= 1'b1;
			end else if (seq_run && state_reg == ST_IDLE && !oneshot_pend_reg
					&& control_reg[BIT_ACTIVATE]) begin
				repeat_pend_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Repeat timer
	// ----------------------------------------
	// Timer is loaded with the start delay when repeat mode is off
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			timer_reg <= 16'h0000;
			timer_first_reg <= 1'b1;
		end else if (!control_reg[BIT_START_REPEAT] || seq_hold) begin
			timer_reg <= delay_reg[15:0];
			timer_first_reg <= 1'b1;
		end else if (repeat_expire) begin
			timer_reg <= delay_reg[31:16];
			timer_first_reg <= 1'b0;
		end else if (seq_run && control_reg[BIT_ACTIVATE]) begin
			timer_reg <= timer_reg - 16'h0001;
		end
	end

	// ----------------------------------------
	// Sequencer state machine
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			remain_reg <= 5'h00;
			mux_sel <= 3'h0;
			conv_cnt_reg <= 5'h00;
			active_is_oneshot_reg <= 1'b0;
			conv_start <= 1'b0;
		end else if (seq_hold) begin
			state_reg <= ST_IDLE;
			remain_reg <= 5'h00;
			conv_start <= 1'b0;
		end else begin
			conv_start <= 1'b0;
			if (seq_run) begin
				case (state_reg)
					ST_IDLE: begin
						// Activate low lets no new cycle start
						if (control_reg[BIT_ACTIVATE] && oneshot_pend_reg) begin
							remain_reg <= oneshot_en_reg;
							active_is_oneshot_reg <= 1'b1;
							state_reg <= ST_PICK;
						end else if (control_reg[BIT_ACTIVATE] && repeat_pend_reg) begin
							remain_reg <= periodic_en_reg;
							active_is_oneshot_reg <= 1'b0;
							state_reg <= ST_PICK;
						end
					end
					ST_PICK: begin
						if (remain_reg == 5'h00) begin
							state_reg <= ST_IDLE; // Empty mask ends at once
						end else begin
							mux_sel <= lowest_chan(remain_reg);
							conv_cnt_reg <= 5'h00;
							conv_start <= 1'b1;
							state_reg <= ST_CONV;
						end
					end
					ST_CONV: begin
						// Fixed conversion window meets the 12 us bound
						if (conv_cnt_reg == 5'(CONV_TICKS - 1)) begin
							remain_reg <= remain_reg & ~(5'h01 << mux_sel);
							state_reg <= (cycle_end) ? ST_IDLE : ST_PICK;
						end else begin
							conv_cnt_reg <= conv_cnt_reg + 5'h01;
						end
					end
					default: begin
						state_reg <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Result capture
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_CHANNELS; i++) begin
				result_reg[i] <= 10'h000;
			end
		end else if (seq_run && state_reg == ST_CONV && conv_cnt_reg == 5'(CONV_TICKS - 1)) begin
			result_reg[mux_sel] <= sample_data;
		end
	end

	// ----------------------------------------
	// Outputs to power and core
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			analog_on <= 1'b0;
			core_reset <= 1'b1;
			activate_prev_reg <= 1'b0;
			oneshot_irq <= 1'b0;
			repeat_irq <= 1'b0;
		end else begin
			activate_prev_reg <= control_reg[BIT_ACTIVATE];
			// Pulse core reset when the block is switched on
			core_reset <= seq_hold || (control_reg[BIT_ACTIVATE] && !activate_prev_reg);
			// Power saver drops analog power between cycles
			analog_on <= (control_reg[BIT_ACTIVATE] && control_reg[BIT_POWER_SAVER_DIS])
				|| (state_reg != ST_IDLE);
			oneshot_irq <= control_reg[BIT_ONESHOT_DONE];
			repeat_irq <= control_reg[BIT_REPEAT_DONE];
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				OFS_CONTROL: reg_rdata <= {24'h000000, control_reg[7:6], 1'b0, control_reg[4:0]};
				OFS_DELAY: reg_rdata <= delay_reg;
				OFS_STATUS: reg_rdata <= {29'h0, timer_first_reg, repeat_pend_reg,
					state_reg != ST_IDLE};
				OFS_ONESHOT_EN: reg_rdata <= {27'h0, oneshot_en_reg};
				OFS_PERIODIC_EN: reg_rdata <= {27'h0, periodic_en_reg};
				OFS_RESULT0: reg_rdata <= {22'h0, result_reg[0]};
				OFS_RESULT1: reg_rdata <= {22'h0, result_reg[1]};
				OFS_RESULT2: reg_rdata <= {22'h0, result_reg[2]};
				OFS_RESULT3: reg_rdata <= {22'h0, result_reg[3]};
				OFS_RESULT4: reg_rdata <= {22'h0, result_reg[4]};
				default: reg_rdata <= 32'h0000_0000; // Unmapped reads zero
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence seq_done_set;
		cycle_end && active_is_oneshot_reg;
	endsequence

	AST_ONESHOT_IRQ: assert property (@(posedge clock) disable iff (!rst_n)
		seq_done_set |-> ##2 oneshot_irq)
		else $error("one-shot interrupt missing");
	AST_REPEAT_IRQ: assert property (@(posedge clock) disable iff (!rst_n)
		(cycle_end && !active_is_oneshot_reg) |-> ##2 repeat_irq)
		else $error("repeat interrupt missing");
	AST_PRIORITY: assert property (@(posedge clock) disable iff (!rst_n)
		(seq_run && state_reg == ST_IDLE && control_reg[BIT_ACTIVATE] && oneshot_pend_reg
		&& !seq_hold) |=> active_is_oneshot_reg)
		else $error("one-shot lost priority");
	AST_NO_START_INACTIVE: assert property (@(posedge clock) disable iff (!rst_n)
		(state_reg == ST_IDLE && !control_reg[BIT_ACTIVATE]) |=> state_reg == ST_IDLE)
		else $error("cycle started while inactive");
	AST_SELF_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
		(control_reg[BIT_START_ONESHOT] && !wr_ctl) |=> !control_reg[BIT_START_ONESHOT])
		else $error("start bit did not clear");
	AST_TICK_RATE: assert property (@(posedge clock) disable iff (!rst_n)
		(tick && !sleep_req) |=> !tick [*8])
		else $error("tick too frequent");
	AST_SLEEP: assert property (@(posedge clock) disable iff (!rst_n)
		sleep_req |=> !tick)
		else $error("tick during sleep");
	AST_LOWEST: assert property (@(posedge clock) disable iff (!rst_n)
		conv_start |-> ((remain_reg & ((5'h01 << mux_sel) - 5'h01)) == 5'h00))
		else $error("channel order wrong");

	// Repeat cycle leaves idle on this tick
	sequence seq_repeat_begin;
		seq_run && state_reg == ST_IDLE && control_reg[BIT_ACTIVATE] && !oneshot_pend_reg
		&& repeat_pend_reg;
	endsequence

	AST_REPEAT_DONE_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
		seq_repeat_begin |=> !control_reg[BIT_REPEAT_DONE])
		else $error("repeat done not cleared");
endmodule : acs_sequencer

// ===== acs_sequencer_tb.sv
// Purpose: Self-checking bench for the converter sequencer
// Assumes: Register port strobes are one cycle wide, read data one cycle late
// Notes: Driver notes expectations in queues, negedge monitor compares them
module tb
	import acs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// Signals and bookkeeping
	// ----------------------------------------
	logic clock = 1'b0; // System clock
	logic rst_n = 1'b0; // Reset, active low
	logic sleep_req = 1'b0; // Sleep request
	logic [7:0] reg_addr = 8'h00; // Register offset
	logic reg_wr = 1'b0; // Write strobe
	logic [31:0] reg_wdata = 32'h0000_0000; // Write data
	logic reg_rd = 1'b0; // Read strobe
	logic [9:0] sample_data = 10'h000; // Core result
	logic [31:0] reg_rdata; // Read data
	logic [2:0] mux_sel; // Channel select
	logic conv_start, analog_on, core_reset; // Converter controls
	logic oneshot_irq, repeat_irq; // Completion interrupts
	logic rd_pend = 1'b0; // Read answer due
	logic [9:0] samp_tbl [NUM_CHANNELS]; // Fixed sample per channel
	logic [31:0] rd_q [$]; // Expected read data
	logic [2:0] ch_q [$]; // Expected channel order
	logic [4:0] m1, m2; // One-shot and repeat masks
	logic an; // Analog enable before sleep
	int n_errors = 0; // Mismatch count
	int check_count = 0; // Comparison count

	always #25 clock = ~clock; // 20 MHz

	acs_sequencer dut_u (
		.clock(clock), .rst_n(rst_n), .sleep_req(sleep_req), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .sample_data(sample_data),
		.reg_rdata(reg_rdata), .mux_sel(mux_sel), .conv_start(conv_start),
		.analog_on(analog_on), .core_reset(core_reset), .oneshot_irq(oneshot_irq),
		.repeat_irq(repeat_irq)
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic end_of_test();
		$display("errors=%0d checks=%0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	// Expectation queued as the strobe goes out
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		rd_q.push_back(e);
		@(posedge clock);
		reg_rd <= 1'b0;
	endtask : rd

	task automatic push_chans(input logic [4:0] m);
		for (int i = 0; i < NUM_CHANNELS; i++) begin
			if (m[i]) begin
				ch_q.push_back(3'(i));
			end
		end
	endtask : push_chans

	task automatic rd_results(input logic [4:0] m);
		for (int i = 0; i < NUM_CHANNELS; i++) begin
			if (m[i]) begin
				rd(OFS_RESULT0 + 8'(4 * i), {22'h0, samp_tbl[i]});
			end
		end
	endtask : rd_results

	// Bounded wait: 0 one-shot irq, 1 repeat irq, 2 conversion start
	task automatic wait_sig(input int which, input int lim);
		int n;
		n = 0;
		while (n < lim) begin
			@(negedge clock);
			if ((which == 0 && oneshot_irq === 1'b1) || (which == 1 && repeat_irq === 1'b1)
				|| (which == 2 && conv_start === 1'b1)) begin
				break;
			end
			n++;
		end
		if (n >= lim) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		end
	endtask : wait_sig

	task automatic idle(input int k);
		repeat (k) @(posedge clock);
	endtask : idle

	// ----------------------------------------
	// Converter core stand-in and monitor
	// ----------------------------------------
	// Fixed value per channel so stored results are predictable
	always @(posedge clock) begin
		sample_data <= (mux_sel < 3'h5) ? samp_tbl[mux_sel] : 10'h000;
	end

	always @(posedge clock) begin
		rd_pend <= reg_rd;
	end

	// Unexpected read or conversion start compares against unknown and fails
	always @(negedge clock) begin
		if (rd_pend) begin
			chk(reg_rdata, (rd_q.size() > 0) ? rd_q.pop_front() : 32'hxxxx_xxxx);
		end
		if (conv_start === 1'b1) begin
			chk({29'h0, mux_sel}, (ch_q.size() > 0) ? {29'h0, ch_q.pop_front()} : 32'hxxxx_xxxx);
		end
	end

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	initial begin
		#(80000 * 50);
		n_errors++;
		end_of_test();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(99));
		for (int i = 0; i < NUM_CHANNELS; i++) begin
			samp_tbl[i] = 10'($urandom);
		end
		m1 = 5'($urandom_range(1, 31));
		m2 = 5'($urandom_range(1, 31));
		idle(3);
		chk(core_reset, 32'h1);
		rst_n <= 1'b1;
		// Reset values, status shows the start delay armed, unmapped 0x28 reads zero
		for (int a = 0; a <= 40; a += 4) begin
			rd(8'(a), (8'(a) == OFS_STATUS) ? 32'h0000_0004 : 32'h0000_0000);
		end
		chk({oneshot_irq, repeat_irq}, 32'h0);
		wr(OFS_ONESHOT_EN, {27'h0, m1});
		wr(OFS_PERIODIC_EN, {27'h0, m2});
		rd(OFS_ONESHOT_EN, {27'h0, m1});
		rd(OFS_PERIODIC_EN, {27'h0, m2});
		// One-shot cycle
		wr(OFS_CONTROL, 32'h01);
		// Core reset pulses on the cycle after activation lands
		@(negedge clock);
		@(negedge clock);
		chk(core_reset, 32'h1);
		push_chans(m1);
		wr(OFS_CONTROL, 32'h03);
		wait_sig(0, 3000);
		rd(OFS_CONTROL, 32'h81);
		rd_results(m1);
		wr(OFS_CONTROL, 32'h01);
		rd(OFS_CONTROL, 32'h81);
		wr(OFS_CONTROL, 32'h81);
		idle(3);
		chk(oneshot_irq, 32'h0);
		rd(OFS_CONTROL, 32'h01);
		// Sleep freezes sequencing, analog untouched
		push_chans(m1);
		wr(OFS_CONTROL, 32'h03);
		idle(100);
		an = analog_on;
		sleep_req <= 1'b1;
		idle(600);
		chk(analog_on, an);
		chk(oneshot_irq, 32'h0);
		sleep_req <= 1'b0;
		wait_sig(0, 3000);
		wr(OFS_CONTROL, 32'h81);
		// Timer expiry during a one-shot runs repeat right after
		wr(OFS_DELAY, {16'h0200, 16'h0004});
		rd(OFS_DELAY, {16'h0200, 16'h0004});
		push_chans(m1);
		push_chans(m2);
		wr(OFS_CONTROL, 32'h07);
		wait_sig(0, 3000);
		wait_sig(1, 3000);
		wr(OFS_CONTROL, 32'hc1);
		// Repeat mode with start delay, then interval
		push_chans(m2);
		wr(OFS_CONTROL, 32'h05);
		wait_sig(1, 3000);
		rd(OFS_CONTROL, 32'h45);
		push_chans(m2);
		wait_sig(2, 10000);
		rd(OFS_CONTROL, 32'h05);
		// One-shot during a repeat cycle, repeat cleared mid-cycle
		push_chans(m1);
		wr(OFS_CONTROL, 32'h07);
		wr(OFS_CONTROL, 32'h01);
		wait_sig(0, 4000);
		chk(repeat_irq, 32'h1);
		idle(9000);
		wr(OFS_CONTROL, 32'hc1);
		// Deactivate mid-cycle finishes cycle then stops
		push_chans(m1);
		wr(OFS_CONTROL, 32'h03);
		// Deactivate only once the cycle has begun, else nothing would run
		wait_sig(2, 100);
		wr(OFS_CONTROL, 32'h00);
		wait_sig(0, 3000);
		idle(2000);
		chk(analog_on, 32'h0);
		chk(ch_q.size(), 32'h0);
		end_of_test();
	end
endmodule : tb
